/* File: rtl/rpsl_top.sv */
// remappable pin select with write lock, key sequence and shadow check
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "rpsl_cfg.svh"
module rpsl_top #(
    parameter logic [1:0] variant = `RPSL_VAR_FULL
) (
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [11:0]                  paddr,
    input  wire logic [31:0]                  pwdata,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    input  wire logic [7:0]                   osc_config_word,
    input  wire logic [`RPSL_NUM_PINS-1:0]    remap_pin_in,
    input  wire logic [`RPSL_NUM_PINS-1:0]    remap_pin_analog,
    output logic      [`RPSL_NUM_IO-1:0]      remap_pin_out,
    output logic      [`RPSL_NUM_IO-1:0]      remap_pin_oe_n,
    input  wire logic [31:0]                  periph_out,
    output logic      [`RPSL_IN_FIELDS-1:0]   periph_in,
    output logic                              map_write_lock,
    output logic                              config_mismatch_reset
);
    rpsl_pkg::rpsl_state_s q;
    rpsl_pkg::rpsl_state_s next_q;

    logic [`RPSL_NUM_PINS-1:0] pin_sync;
    logic                      setup;
    logic                      access;
    logic [4:0]                idx;
    logic                      in_hit;
    logic                      out_hit;
    logic                      osc_hit;
    logic                      fuse_active;

    // pins absent on smaller package variants
    function automatic logic pin_ok(input logic [5:0] pin);
        logic ok;
        ok = (pin < 6'(`RPSL_NUM_PINS));
        if (variant != `RPSL_VAR_FULL && pin >= 6'(`RPSL_NUM_IO)) begin
            ok = 1'b0;
        end
        if (variant == `RPSL_VAR_SMALL && pin >= 6'(`RPSL_SMALL_GAP_LO)
            && pin <= 6'(`RPSL_SMALL_GAP_HI)) begin
            ok = 1'b0;
        end
        return ok;
    endfunction : pin_ok

    // an output field exists only for an implemented two-way pin
    function automatic logic out_field_ok(input int f);
        return (f < `RPSL_NUM_IO) && pin_ok(6'(f));
    endfunction : out_field_ok

    function automatic logic in_field_ok(input int f);
        logic [`RPSL_IN_FIELDS-1:0] mask;
        mask = `RPSL_IN_MASK;
        return mask[f];
    endfunction : in_field_ok

    rpsl_pin_sync u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .pin_raw  (remap_pin_in),
        .pin_sync (pin_sync)
    );

    // address decode; each register is one aligned word
    assign setup       = psel && !penable;
    assign access      = psel && penable;
    assign idx         = paddr[6:2];
    assign in_hit      = (paddr[11:7] == `RPSL_REGION_IN) && (idx < 5'(`RPSL_IN_REGS));
    assign out_hit     = (paddr[11:7] == `RPSL_REGION_OUT) && (idx < 5'(`RPSL_OUT_REGS));
    assign osc_hit     = (paddr == `RPSL_OSC_ADDR);
    assign fuse_active = osc_config_word[`RPSL_FUSE_BIT];

    // the slave never inserts wait states
    assign pready  = 1'b1;
    assign pslverr = access && !(in_hit || out_hit || osc_hit);

    always_comb begin
        int          f0;
        int          f1;
        logic        osc_wr;
        logic        new_lock;
        logic [31:0] rd;
        next_q   = q;
        f0       = 2 * int'(idx);
        f1       = f0 + 1;
        osc_wr   = access && pwrite && osc_hit;
        new_lock = pwdata[`RPSL_LOCK_BIT];
        rd       = '0;

        // read data captured in the setup cycle, unimplemented bits zero
        if (setup && !pwrite) begin
            if (in_hit) begin
                if (in_field_ok(f0)) begin
                    rd[`RPSL_LO_LSB +: `RPSL_SEL_W] = q.in_sel[f0];
                end
                if (in_field_ok(f1)) begin
                    rd[`RPSL_HI_LSB +: `RPSL_SEL_W] = q.in_sel[f1];
                end
            end else if (out_hit) begin
                if (out_field_ok(f0)) begin
                    rd[`RPSL_LO_LSB +: `RPSL_SEL_W] = q.out_sel[f0];
                end
                if (out_field_ok(f1)) begin
                    rd[`RPSL_HI_LSB +: `RPSL_SEL_W] = q.out_sel[f1];
                end
            end else if (osc_hit) begin
                rd[`RPSL_LOCK_BIT] = q.lock;
            end
            next_q.prdata = rd;
        end

        // selector writes; a locked write still completes without error
        if (access && pwrite && !q.lock) begin
            if (in_hit) begin
                if (in_field_ok(f0)) begin
                    next_q.in_sel[f0]    = pwdata[`RPSL_LO_LSB +: `RPSL_SEL_W];
                    next_q.in_shadow[f0] = pwdata[`RPSL_LO_LSB +: `RPSL_SEL_W];
                end
                if (in_field_ok(f1)) begin
                    next_q.in_sel[f1]    = pwdata[`RPSL_HI_LSB +: `RPSL_SEL_W];
                    next_q.in_shadow[f1] = pwdata[`RPSL_HI_LSB +: `RPSL_SEL_W];
                end
            end
            if (out_hit) begin
                if (out_field_ok(f0)) begin
                    next_q.out_sel[f0]    = pwdata[`RPSL_LO_LSB +: `RPSL_SEL_W];
                    next_q.out_shadow[f0] = pwdata[`RPSL_LO_LSB +: `RPSL_SEL_W];
                end
                if (out_field_ok(f1)) begin
                    next_q.out_sel[f1]    = pwdata[`RPSL_HI_LSB +: `RPSL_SEL_W];
                    next_q.out_shadow[f1] = pwdata[`RPSL_HI_LSB +: `RPSL_SEL_W];
                end
            end
        end

        // key sequence: every completed transfer advances or abandons it
        if (access) begin
            unique case (q.key)
                rpsl_pkg::KEY_IDLE: begin
                    if (osc_wr && pwdata[7:0] == `RPSL_KEY1) begin
                        next_q.key = rpsl_pkg::KEY_FIRST;
                    end
                end
                rpsl_pkg::KEY_FIRST: begin
                    if (osc_wr && pwdata[7:0] == `RPSL_KEY2) begin
                        next_q.key = rpsl_pkg::KEY_ARMED;
                    end else if (osc_wr && pwdata[7:0] == `RPSL_KEY1) begin
                        next_q.key = rpsl_pkg::KEY_FIRST; // a fresh first key restarts
                    end else begin
                        next_q.key = rpsl_pkg::KEY_IDLE;
                    end
                end
                rpsl_pkg::KEY_ARMED: begin
                    next_q.key = rpsl_pkg::KEY_IDLE;
                    if (osc_wr) begin
                        // fuse keeps a once-set lock until reset
                        if (!(fuse_active && q.lock_once && !new_lock)) begin
                            next_q.lock = new_lock;
                        end
                    end
                end
            endcase
        end
        // lock otherwise just holds its value
        next_q.lock_once = q.lock_once | next_q.lock;

        // sticky: any divergence from the shadows is a fault
        if ((q.in_sel != q.in_shadow) || (q.out_sel != q.out_shadow)) begin
            next_q.mismatch = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q            <= '0;
            q.in_sel     <= {`RPSL_IN_FIELDS{`RPSL_IN_RST}};
            q.in_shadow  <= {`RPSL_IN_FIELDS{`RPSL_IN_RST}};
            q.out_sel    <= {`RPSL_OUT_FIELDS{`RPSL_OUT_RST}};
            q.out_shadow <= {`RPSL_OUT_FIELDS{`RPSL_OUT_RST}};
            q.lock       <= 1'b0;
            q.key        <= rpsl_pkg::KEY_IDLE;
        end else begin
            q <= next_q;
        end
    end

    // input routing per peripheral input; any pin may feed many inputs
    for (genvar gf = 0; gf < `RPSL_IN_FIELDS; gf++) begin : g_in
        logic [5:0] sel;
        logic       valid;
        assign sel   = q.in_sel[gf];
        assign valid = in_field_ok(gf) && pin_ok(sel);
        // analog pins read low to the peripheral
        assign periph_in[gf] = valid && pin_sync[sel[5:0] % 6'(`RPSL_NUM_PINS)]
                               && !remap_pin_analog[sel[5:0] % 6'(`RPSL_NUM_PINS)];
    end

    // output routing per pin; one peripheral output may go to many pins
    for (genvar gp = 0; gp < `RPSL_NUM_IO; gp++) begin : g_out
        logic [5:0] code;
        logic       drive;
        assign code  = q.out_sel[gp];
        assign drive = out_field_ok(gp) && code != `RPSL_CODE_NULL
                       && code != `RPSL_CODE_RSVD && !code[5];
        // only a drive request; direction and other pin settings stay outside
        assign remap_pin_out[gp]  = drive && periph_out[code[4:0]];
        assign remap_pin_oe_n[gp] = !(drive && !remap_pin_analog[gp]);
    end

    // no lockout: each selector is independent of every other
    assign prdata                = q.prdata;
    assign map_write_lock        = q.lock;
    assign config_mismatch_reset = q.mismatch;
endmodule : rpsl_top
`default_nettype wire

/* File: rtl/rpsl_cfg.svh */
// constants of the remappable pin select block with write lock
// Function
// - output code 0 none, 1-31 peripherals, 22 reserved
// - one pin many inputs, one output many pins
// - no lockout on mapping combinations
// - unimplemented input pin number feeds nothing
// - absent pin output fields unimplemented, writes ignored
// - locked selector writes complete, contents unchanged
// - lock is osc control bit 6
// - keys 46h then 57h before lock change
// - lock holds until explicitly changed
// - shadow compare divergence raises mismatch reset
// - fuse set: lock set once stays set
// - fuse set unprogrammed allows single session
// - reset: inputs 111111, outputs 000000
// - lock comes out of reset cleared
// - mapping enables nothing else on pin
// - analog pin blocks remapped function
// - small variant lacks 16-25, 29-32; middle 29-32
// - input field is 6-bit pin number
// - output register holds two 6-bit pin fields
// - remapped input disabled on analog pin
`ifndef RPSL_CFG_SVH
`define RPSL_CFG_SVH

`define RPSL_NUM_PINS     33
`define RPSL_NUM_IO       29
`define RPSL_IN_REGS      30
`define RPSL_OUT_REGS     15
`define RPSL_IN_FIELDS    60
`define RPSL_OUT_FIELDS   30
`define RPSL_SEL_W        6
`define RPSL_IN_RST       6'h3f
`define RPSL_OUT_RST      6'h00
`define RPSL_CODE_NULL    6'h00
`define RPSL_CODE_RSVD    6'h16
`define RPSL_IN_MASK      60'h70cf7f003c1fcff
`define RPSL_LO_LSB       0
`define RPSL_HI_LSB       8
`define RPSL_REGION_IN    5'h00
`define RPSL_REGION_OUT   5'h01
`define RPSL_OSC_ADDR     12'h100
`define RPSL_LOCK_BIT     6
`define RPSL_FUSE_BIT     5
`define RPSL_KEY1         8'h46
`define RPSL_KEY2         8'h57
`define RPSL_VAR_FULL     2'h0
`define RPSL_VAR_MID      2'h1
`define RPSL_VAR_SMALL    2'h2
`define RPSL_SMALL_GAP_LO 16
`define RPSL_SMALL_GAP_HI 25

`endif

/* File: rtl/rpsl_pkg.sv */
// types of the remappable pin select block
`include "rpsl_cfg.svh"
package rpsl_pkg;
    typedef enum logic [1:0] {KEY_IDLE, KEY_FIRST, KEY_ARMED} rpsl_key_e;

    typedef logic [`RPSL_SEL_W-1:0] rpsl_sel_t;

    typedef struct packed {
        rpsl_sel_t [`RPSL_IN_FIELDS-1:0]  in_sel;
        rpsl_sel_t [`RPSL_IN_FIELDS-1:0]  in_shadow;
        rpsl_sel_t [`RPSL_OUT_FIELDS-1:0] out_sel;
        rpsl_sel_t [`RPSL_OUT_FIELDS-1:0] out_shadow;
        logic                             lock;
        logic                             lock_once;
        rpsl_key_e                        key;
        logic                             mismatch;
        logic [31:0]                      prdata;
    } rpsl_state_s;

    typedef struct packed {
        logic [`RPSL_NUM_PINS-1:0] s1;
        logic [`RPSL_NUM_PINS-1:0] s2;
        logic [`RPSL_NUM_PINS-1:0] s3;
        logic [`RPSL_NUM_PINS-1:0] q;
    } rpsl_sync_s;
endpackage : rpsl_pkg

/* File: rtl/rpsl_pin_sync.sv */
// three-stage synchroniser for the remappable pin inputs
`timescale 1ns/1ps
`default_nettype none
`include "rpsl_cfg.svh"
module rpsl_pin_sync (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic [`RPSL_NUM_PINS-1:0] pin_raw,
    output logic      [`RPSL_NUM_PINS-1:0] pin_sync
);
    rpsl_pkg::rpsl_sync_s q;
    rpsl_pkg::rpsl_sync_s next_q;

    // s1 feeds only s2; a level counts once s2 and s3 agree
    always_comb begin
        next_q    = q;
        next_q.s1 = pin_raw;
        next_q.s2 = q.s1;
        next_q.s3 = q.s2;
        next_q.q  = (q.s2 & q.s3) | (q.q & (q.s2 | q.s3)); // hold on disagreement
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign pin_sync = q.q;
endmodule : rpsl_pin_sync
`default_nettype wire

/* File: dv/rpsl_periph_model.sv */
// peripheral outputs and pad wires facing the pin select block
`timescale 1ns/1ps
`default_nettype none
`include "rpsl_cfg.svh"
module rpsl_periph_model (
    input  wire logic [31:1] periph_level,
    input  wire logic [32:0] pad_level,
    input  wire logic [28:0] remap_pin_out,
    input  wire logic [28:0] remap_pin_oe_n,
    input  wire logic        pclk,
    output logic      [31:0] periph_out,
    output logic      [32:0] remap_pin_in
);
    logic junk = 1'b0;
    // code 0 has no source: keep its bit moving so nothing can lean on it
    always @(posedge pclk) begin
        junk <= ~junk;
    end
    // peripherals run whether mapped or not; mapping enables nothing
    assign periph_out = {periph_level, junk};
    // wire level: a driving remapped output wins over the outside pad
    assign remap_pin_in = {pad_level[32:29],
        (remap_pin_oe_n & pad_level[28:0]) | (~remap_pin_oe_n & remap_pin_out)};
endmodule : rpsl_periph_model
`default_nettype wire

/* File: dv/rpsl_top_chk.sv */
// bus, lock and pin enable checks of the pin select block
`timescale 1ns/1ps
`default_nettype none
module rpsl_top_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [7:0]  osc_config_word,
    input wire logic [32:0] remap_pin_analog,
    input wire logic [28:0] remap_pin_oe_n,
    input wire logic        map_write_lock,
    input wire logic        config_mismatch_reset
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // completed write to the oscillator control word
    wire logic osc_wr = psel && penable && pwrite && paddr == 12'h100;
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    a_locked_noerr: assert property (s_access and map_write_lock && paddr >= 12'h080
        && paddr <= 12'h0b8 |-> pready && !pslverr) else $error("locked write errored");
    a_unmapped_err: assert property (s_access and paddr >= 12'h104 |-> pslverr && pready)
        else $error("unmapped access not refused");
    a_osc_mapped: assert property (s_access and paddr == 12'h100 |-> !pslverr)
        else $error("osc control refused");
    a_lock_cause: assert property ($changed(map_write_lock) |-> $past(osc_wr)
        && $past(pwdata[6]) == map_write_lock) else $error("lock moved without write");
    a_fuse_hold: assert property (map_write_lock && osc_config_word[5] |=> map_write_lock)
        else $error("fused lock cleared");
    a_rdata_hold: assert property (s_setup ##1 s_access |=> $stable(prdata))
        else $error("read data moved");
    a_analog_blocks: assert property ((remap_pin_analog[28:0] & ~remap_pin_oe_n) == '0)
        else $error("analog pin driven");
    a_no_mismatch: assert property (!config_mismatch_reset)
        else $error("mismatch reset in normal use");
endmodule : rpsl_top_chk
bind rpsl_top rpsl_top_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .osc_config_word(osc_config_word),
    .remap_pin_analog(remap_pin_analog), .remap_pin_oe_n(remap_pin_oe_n),
    .map_write_lock(map_write_lock), .config_mismatch_reset(config_mismatch_reset));
`default_nettype wire

/* File: dv/rpsl_top_tb.sv */
// self-checking bench of the pin select block
`timescale 1ns/1ps
`default_nettype none
`include "rpsl_cfg.svh"
module rpsl_top_tb;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd, periph_out;
    logic        pready, pslverr, err, map_write_lock, config_mismatch_reset;
    logic [7:0]  osc_config_word = '0;
    logic [32:0] pad_level = '0, remap_pin_analog = '0, remap_pin_in;
    logic [31:1] periph_level = '0;
    logic [28:0] remap_pin_out, remap_pin_oe_n;
    logic [59:0] periph_in, periph_in_s;
    logic [31:0] prdata_s, rd_s;
    logic [28:0] oe_n_s;
    int          errors = 0, samples_checked = 0, cyc = 0;
    rpsl_top #(.variant(`RPSL_VAR_FULL)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .osc_config_word(osc_config_word), .remap_pin_in(remap_pin_in),
        .remap_pin_analog(remap_pin_analog), .remap_pin_out(remap_pin_out),
        .remap_pin_oe_n(remap_pin_oe_n), .periph_out(periph_out), .periph_in(periph_in),
        .map_write_lock(map_write_lock), .config_mismatch_reset(config_mismatch_reset));
    // second copy in the smallest package, to see absent pins ignored
    rpsl_top #(.variant(`RPSL_VAR_SMALL)) dut_small (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata_s), .pready(), .pslverr(),
        .osc_config_word(osc_config_word), .remap_pin_in(remap_pin_in),
        .remap_pin_analog(remap_pin_analog), .remap_pin_out(),
        .remap_pin_oe_n(oe_n_s), .periph_out(periph_out), .periph_in(periph_in_s),
        .map_write_lock(), .config_mismatch_reset());
    rpsl_periph_model pm (.periph_level(periph_level), .pad_level(pad_level),
        .remap_pin_out(remap_pin_out), .remap_pin_oe_n(remap_pin_oe_n), .pclk(pclk),
        .periph_out(periph_out), .remap_pin_in(remap_pin_in));
    always #25 pclk = ~pclk;
    // hang guard, over ten times the expected run
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            test_done;
        end
    end
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // one transfer; returns off the edge so outputs have settled
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        // only the cycle ceiling ends a wait that never answers
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        rd_s = prdata_s;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(negedge pclk);
    endtask : apb
    // keys go out back to back, nothing in between
    task automatic set_lock(input logic v);
        apb(1, 12'h100, 32'h46);
        apb(1, 12'h100, 32'h57);
        apb(1, 12'h100, {25'h0, v, 6'h0});
    endtask : set_lock
    task automatic t_reset;
        check(map_write_lock, 0);
        check(periph_in, 60'h0);
        check(remap_pin_oe_n, 29'h1fffffff);
        apb(0, 12'h000, 0);
        check(rd, 32'h3f3f);
        apb(0, 12'h020, 0);
        check(rd, 32'h3f);
        apb(0, 12'h080, 0);
        check(rd, 0);
        $display("test reset done");
    endtask : t_reset
    task automatic t_map;
        @(posedge pclk);
        periph_level <= 31'h2d4b3c6a;
        for (int c = 1; c < 32; c++) begin
            apb(1, 12'h080, c);
            check({remap_pin_oe_n[0], remap_pin_out[0]},
                {c == 22, periph_level[c] & (c != 22)});
        end
        // code 4 carries a high level, so the looped-back input shows ones
        apb(1, 12'h084, 32'h0404);
        apb(1, 12'h000, 32'h0202);
        repeat (6) @(posedge pclk);
        @(negedge pclk);
        check({remap_pin_oe_n[3:2], remap_pin_out[3:2], periph_in[1:0]},
            {2'b00, {4{periph_level[4]}}});
        @(posedge pclk);
        remap_pin_analog[3] <= 1;
        apb(1, 12'h084, 32'h0316);
        check(remap_pin_oe_n[3:2], 2'b11);
        $display("test mapping done");
    endtask : t_map
    task automatic t_variant;
        @(posedge pclk);
        pad_level[20] <= 1;
        apb(1, 12'h0a0, 32'h0303);
        check({oe_n_s[17:16], remap_pin_oe_n[17:16]}, 4'b1100);
        apb(0, 12'h0a0, 0);
        check({rd_s, rd}, {32'h0, 32'h0303});
        apb(1, 12'h004, 32'h1414);
        repeat (4) @(posedge pclk);
        @(negedge pclk);
        check({periph_in_s[3:2], periph_in[3:2]}, 4'b0011);
        @(posedge pclk);
        remap_pin_analog[20] <= 1;
        @(negedge pclk);
        check(periph_in[3:2], 2'b00);
        @(posedge pclk);
        remap_pin_analog[20] <= 0;
        @(negedge pclk);
        check(periph_in[3:2], 2'b11);
        // park the input on an absent pin and null the outputs
        apb(1, 12'h004, 32'h2121);
        apb(1, 12'h0a0, 32'h0);
        check({periph_in[3:2], remap_pin_oe_n[17:16]}, 4'b0011);
        $display("test variant done");
    endtask : t_variant
    task automatic t_lock;
        set_lock(1);
        check(map_write_lock, 1);
        apb(1, 12'h080, 32'h0505);
        check(err, 0);
        apb(0, 12'h080, 0);
        check(rd, 32'h1f);
        apb(1, 12'h100, 32'h46);
        apb(0, 12'h000, 0);
        apb(1, 12'h100, 32'h57);
        apb(1, 12'h100, 32'h0);
        check(map_write_lock, 1);
        set_lock(0);
        check(map_write_lock, 0);
        apb(1, 12'h080, 32'h0a09);
        apb(1, 12'h0b8, 32'h0d0c);
        apb(0, 12'h080, 0);
        check(rd, 32'h0a09);
        apb(0, 12'h0b8, 0);
        check(rd, 32'h000c);
        apb(0, 12'h200, 0);
        check({err, rd}, {1'b1, 32'h0});
        $display("test lock done");
    endtask : t_lock
    task automatic t_fuse;
        @(posedge pclk);
        osc_config_word <= 8'h20;
        set_lock(1);
        set_lock(0);
        check(map_write_lock, 1);
        @(posedge pclk);
        presetn <= 0;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        @(negedge pclk);
        check(map_write_lock, 0);
        apb(0, 12'h084, 0);
        check(rd, 0);
        $display("test fuse done");
    endtask : t_fuse
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : test_done
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1;
        @(negedge pclk);
        t_reset;
        t_map;
        t_variant;
        t_lock;
        t_fuse;
        test_done;
    end
endmodule : rpsl_top_tb
`default_nettype wire
